// ### core/sfc_core.sv
// serial port fault, interrupt, reset control with transmit fifo
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.svh"

//------------------------------------------------------------------
// transmit fifo
//------------------------------------------------------------------
module sfc_fifo
    import sfc_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 32
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sfc_fifo_t;
    sfc_fifo_t r_reg;
    sfc_fifo_t r_next;
    logic push;
    logic pop;

    // honest full and empty straight from the count
    assign in_ready = (r_reg.cnt != (AW+1)'(D));
    assign out_valid = (r_reg.cnt != '0);
    assign out_data = r_reg.mem[r_reg.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb
    begin
        r_next = r_reg;
        if (push)
        begin
            r_next.mem[r_reg.wp] = in_data;
            r_next.wp = (r_reg.wp == AW'(D-1)) ? '0 : r_reg.wp + 1'b1;
        end
        if (pop)
        begin
            r_next.rp = (r_reg.rp == AW'(D-1)) ? '0 : r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end
endmodule

//------------------------------------------------------------------
// port core
//------------------------------------------------------------------
module sfc_core
    import sfc_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire sfc_ctrl_t ctrl_wdata,
    input wire logic cfg_wr,
    input wire sfc_cfg_t cfg_wdata,
    input wire logic status_read,
    input wire logic data_read,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire sfc_pin_in_t pins_in,
    output sfc_pin_out_t pins_out,
    output sfc_ctrl_t ctrl_q,
    output sfc_cfg_t cfg_q,
    output sfc_flags_t flags_q,
    output logic [7:0] rx_data,
    output logic tx_irq,
    output logic rx_err_irq,
    output logic wake_req,
    output logic pins_owned
);
    sfc_state_t r_reg;
    sfc_state_t r_next;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_take;
    logic acc_ok;
    logic en;
    logic mst;
    logic ss_hi;
    logic ss_rise;
    logic ss_fall;
    logic lead;
    logic trail;
    logic fault_cond;
    logic [5:0] hmax;

    // cpu queues bytes here; back-pressure reaches the writer via tx_ready
    sfc_fifo #(
        .W(8),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );

    // register accesses are blocked in wait and stop
    assign acc_ok = !wait_mode && !stop_mode;
    assign en = r_reg.ctrl.module_enable;
    assign mst = r_reg.ctrl.master_select_bit;

    // a fifo pop is the transmit data register write
    assign fifo_take = fifo_valid && r_reg.flags.transmit_empty_flag
        && en && !stop_mode;

    // edge finding only on the second and third sync stages
    assign ss_hi = r_reg.s2.select_n;
    assign ss_rise = r_reg.s2.select_n && !r_reg.s3.select_n;
    assign ss_fall = !r_reg.s2.select_n && r_reg.s3.select_n;
    assign lead = ((r_reg.s2.serial_clock_pin ^ r_reg.ctrl.cpol)
        && !(r_reg.s3.serial_clock_pin ^ r_reg.ctrl.cpol));
    assign trail = (!(r_reg.s2.serial_clock_pin ^ r_reg.ctrl.cpol)
        && (r_reg.s3.serial_clock_pin ^ r_reg.ctrl.cpol));

    // select inconsistent with role, only with fault detect on
    assign fault_cond = r_reg.cfg.fault_detect_enable && en &&
        (mst ? !ss_hi : (r_reg.active && ss_rise));

    // master half period from rate select
    always_comb
    begin
        unique case ({r_reg.cfg.rate_select_high, r_reg.cfg.rate_select_low})
            2'h0: hmax = `SFC_HALF_DIV2;
            2'h1: hmax = `SFC_HALF_DIV8;
            2'h2: hmax = `SFC_HALF_DIV32;
            2'h3: hmax = `SFC_HALF_DIV128;
        endcase
    end

    // whole next state
    always_comb
    begin
        logic smp;
        logic fin;
        logic start;
        smp = 1'b0;
        fin = 1'b0;
        start = 1'b0;
        r_next = r_reg;
        // two-stage sync plus a history stage for edges
        r_next.s1 = pins_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;

        // cpu control writes
        if (acc_ok && ctrl_wr)
        begin
            r_next.ctrl = ctrl_wdata;
        end
        if (acc_ok && cfg_wr)
        begin
            r_next.cfg = cfg_wdata;
        end

        // byte into transmit data register
        if (fifo_take)
        begin
            r_next.tdr = fifo_data;
            r_next.flags.transmit_empty_flag = 1'b0;
        end

        // first step of the two-step clears
        if (acc_ok && status_read)
        begin
            r_next.rf_arm = r_reg.flags.receive_full_flag;
            r_next.of_arm = r_reg.flags.overflow_flag;
            r_next.mf_arm = r_reg.flags.mode_fault_flag
                && !fault_cond;
        end
        // second step; a set later in this process still wins
        if (acc_ok && data_read && r_reg.rf_arm)
        begin
            r_next.flags.receive_full_flag = 1'b0;
            r_next.rf_arm = 1'b0;
        end
        if (acc_ok && data_read && r_reg.of_arm)
        begin
            r_next.flags.overflow_flag = 1'b0;
            r_next.of_arm = 1'b0;
        end
        if (acc_ok && ctrl_wr && r_reg.mf_arm && !fault_cond)
        begin
            r_next.flags.mode_fault_flag = 1'b0;
            r_next.mf_arm = 1'b0;
        end

        // master engine
        if (en && mst)
        begin
            if (!r_reg.active && !r_reg.flags.transmit_empty_flag)
            begin
                start = 1'b1;
                r_next.active = 1'b1;
                r_next.shreg = r_reg.tdr;
                r_next.bits = '0;
                r_next.edges = '0;
                r_next.half = '0;
                r_next.sck = 1'b0;
            end
            else if (r_reg.active)
            begin
                if (r_reg.half == hmax)
                begin
                    r_next.half = '0;
                    r_next.sck = !r_reg.sck;
                    r_next.edges = r_reg.edges + 5'h01;
                    // leading edges are the even ones
                    smp = (r_reg.edges[0] == r_reg.ctrl.cpha);
                    fin = (r_reg.edges == `SFC_LAST_EDGE);
                end
                else
                begin
                    r_next.half = r_reg.half + 6'h01;
                end
            end
            if (smp)
            begin
                r_next.shreg = {r_reg.shreg[6:0], r_reg.s2.miso};
            end
        end

        // slave engine
        if (en && !mst)
        begin
            if (ss_hi)
            begin
                // deselect drops the transfer and every clock edge
                r_next.active = 1'b0;
            end
            else if (!r_reg.active)
            begin
                start = r_reg.ctrl.cpha ? lead : ss_fall;
                if (start)
                begin
                    r_next.active = 1'b1;
                    r_next.bits = '0;
                end
            end
            else
            begin
                smp = (r_reg.ctrl.cpha ? trail : lead);
                if (smp)
                begin
                    r_next.shreg = {r_reg.shreg[6:0], r_reg.s2.mosi};
                    r_next.bits = r_reg.bits + 4'h1;
                end
                // end when the clock is back at idle after bit eight
                fin = trail && (r_next.bits == `SFC_BITS);
            end
            // no new data keeps the last shifted byte
            if (start && !r_reg.flags.transmit_empty_flag)
            begin
                r_next.shreg = r_reg.tdr;
            end
        end

        // tx empty rises with each load of the shifter
        if (start && !r_reg.flags.transmit_empty_flag)
        begin
            r_next.flags.transmit_empty_flag = 1'b1;
        end

        // bit counting for the master; slave counts above
        if (smp && mst)
        begin
            r_next.bits = r_reg.bits + 4'h1;
        end

        // overflow at the bit one capture strobe
        if (smp && r_reg.bits == `SFC_OVF_BIT
            && r_reg.flags.receive_full_flag)
        begin
            r_next.flags.overflow_flag = 1'b1;
        end

        // completion hands the byte over unless overflow blocks it
        if (fin)
        begin
            r_next.active = 1'b0;
            if (!r_next.flags.overflow_flag)
            begin
                r_next.rdr = r_next.shreg;
                r_next.flags.receive_full_flag = 1'b1;
            end
        end

        // mode fault in either role; master bit left alone
        if (fault_cond)
        begin
            r_next.flags.mode_fault_flag = 1'b1;
            r_next.mf_arm = 1'b0;
            if (mst)
            begin
                r_next.ctrl.module_enable = 1'b0;
                r_next.flags.transmit_empty_flag = 1'b1;
                r_next.active = 1'b0;
                r_next.bits = '0;
                r_next.edges = '0;
            end
        end

        // partial reset sets tx empty; other flags and control bits survive it
        if (!en)
        begin
            r_next.flags.transmit_empty_flag = 1'b1;
            r_next.active = 1'b0;
            r_next.shreg = '0;
            r_next.bits = '0;
            r_next.edges = '0;
            r_next.half = '0;
            r_next.sck = 1'b0;
        end

        // stop freezes the core state; dropping stop_mode or rst restarts it
        if (stop_mode)
        begin
            r_next = r_reg;
        end
    end

    // the single state register; system reset only
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r_reg <= '0;
            r_reg.ctrl <= `SFC_CTRL_RST;
            r_reg.cfg <= `SFC_CFG_RST;
            r_reg.flags.transmit_empty_flag <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    //------------------------------------------------------------------
    // pins and requests
    //------------------------------------------------------------------
    // directions follow role; disabled port hands pins back
    always_comb
    begin
        pins_out.sclk_o = r_reg.sck ^ r_reg.ctrl.cpol;
        pins_out.sclk_oe = en && mst;
        pins_out.mosi_o = r_reg.shreg[7];
        pins_out.mosi_oe = en && mst;
        pins_out.miso_o = r_reg.shreg[7];
        pins_out.miso_oe = en && !mst && !ss_hi;
    end

    assign pins_owned = en;
    assign ctrl_q = r_reg.ctrl;
    assign cfg_q = r_reg.cfg;
    assign flags_q = r_reg.flags;
    assign rx_data = r_reg.rdr;

    // interrupt requests; any of them wakes the cpu
    assign tx_irq = r_reg.flags.transmit_empty_flag
        && r_reg.ctrl.tx_empty_irq_enable && en;
    assign rx_err_irq = (r_reg.flags.receive_full_flag
        && r_reg.ctrl.rx_full_irq_enable)
        || ((r_reg.flags.overflow_flag || r_reg.flags.mode_fault_flag)
        && r_reg.cfg.error_irq_enable);
    assign wake_req = tx_irq || rx_err_irq;
endmodule
`default_nettype wire

// ### core/sfc_defines.svh
// constants for the serial port fault, interrupt and reset control block
//------------------------------------------------------------------
// Contract
// - slave with fault detect sets mode fault if select rises mid-transfer.
// - master with fault detect sets mode fault whenever select is low.
// - mode fault sets only while fault detect enabled; disabling keeps flag.
// - master fault: error irq, clear enable, set tx empty, reset counter, free pins.
// - master drives clock and mosi, reads miso; slave reverses directions.
// - phase zero slave transfer starts at select fall, ends after eighth bit.
// - phase one slave transfer starts at first clock edge with select low.
// - phase zero select-deselect faults without clocks; phase one does not.
// - slave fault raises error irq only; master select bit never changes.
// - deselected slave floats miso and ignores all serial clock edges.
// - mode fault clears by status read then control write, no fault present.
// - tx empty requests irq only with its enable and module enable.
// - rx full requests irq with its enable, regardless of module enable.
// - one error enable gates overflow and mode fault onto shared request.
// - rx full clears by status read seeing it, then data read.
// - tx empty clears only by a write to the transmit data register.
// - tx empty sets when a byte moves into the shift register.
// - rx full sets when a byte moves into the receive register.
// - enable low: tx empty held, abort, clear shifter and counter, free pins.
// - control bits and rx, overflow, fault flags reset only by system reset.
// - wait mode keeps running, cpu access blocked, enabled irq wakes cpu.
// - stop mode freezes state; leaving by reset aborts and resets module.
// - overflow sets if rx data unread at bit one capture; blocks receives.
// - overflow clears by status read then data read.
//------------------------------------------------------------------
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
`define SFC_BITS 4'h8
`define SFC_OVF_BIT 4'h6
`define SFC_LAST_EDGE 5'h0F
`define SFC_HALF_DIV2 6'h00
`define SFC_HALF_DIV8 6'h03
`define SFC_HALF_DIV32 6'h0F
`define SFC_HALF_DIV128 6'h3F
`define SFC_CTRL_RST 6'h10
`define SFC_CFG_RST 4'h0
`endif

// ### core/sfc_pkg.sv
// types shared by the serial port control block
`default_nettype none
package sfc_pkg;
    typedef struct packed {
        logic rx_full_irq_enable;
        logic master_select_bit;
        logic cpol;
        logic cpha;
        logic module_enable;
        logic tx_empty_irq_enable;
    } sfc_ctrl_t;
    typedef struct packed {
        logic fault_detect_enable;
        logic error_irq_enable;
        logic rate_select_high;
        logic rate_select_low;
    } sfc_cfg_t;
    typedef struct packed {
        logic receive_full_flag;
        logic transmit_empty_flag;
        logic overflow_flag;
        logic mode_fault_flag;
    } sfc_flags_t;
    typedef struct packed {
        logic serial_clock_pin;
        logic select_n;
        logic mosi;
        logic miso;
    } sfc_pin_in_t;
    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } sfc_pin_out_t;
    typedef struct packed {
        sfc_ctrl_t ctrl;
        sfc_cfg_t cfg;
        sfc_flags_t flags;
        logic [7:0] tdr;
        logic [7:0] rdr;
        logic [7:0] shreg;
        logic [3:0] bits;
        logic [4:0] edges;
        logic [5:0] half;
        logic sck;
        logic active;
        sfc_pin_in_t s1;
        sfc_pin_in_t s2;
        sfc_pin_in_t s3;
        logic rf_arm;
        logic of_arm;
        logic mf_arm;
    } sfc_state_t;
endpackage
`default_nettype wire

// ### tb/sfc_chk.sv
// assertion checker for the serial port control block
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------------
// checker
//------------------------------------------------------------------
module sfc_chk
    import sfc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire logic stop_mode,
    input wire sfc_pin_in_t pins_in,
    input wire sfc_pin_out_t pins_out,
    input wire sfc_ctrl_t ctrl_q,
    input wire sfc_cfg_t cfg_q,
    input wire sfc_flags_t flags_q,
    input wire logic tx_irq,
    input wire logic rx_err_irq,
    input wire logic wake_req,
    input wire logic pins_owned
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // a fault set with no control write in the same edge
    sequence fault_rise;
        $rose(flags_q.mode_fault_flag) && !$past(ctrl_wr);
    endsequence
    // every pin driver handed back
    sequence pins_free;
        !pins_out.sclk_oe && !pins_out.mosi_oe && !pins_out.miso_oe;
    endsequence
    tx_irq_a: assert property (
        tx_irq == (flags_q.transmit_empty_flag
            && ctrl_q.tx_empty_irq_enable && ctrl_q.module_enable))
        else $error("transmit request gating wrong");
    err_irq_a: assert property (
        rx_err_irq == (flags_q.receive_full_flag && ctrl_q.rx_full_irq_enable
            || cfg_q.error_irq_enable
            && (flags_q.overflow_flag || flags_q.mode_fault_flag)))
        else $error("receive or error request wrong");
    wake_a: assert property (
        wake_req == (tx_irq || rx_err_irq))
        else $error("wake request wrong");
    fault_gate_a: assert property (
        $rose(flags_q.mode_fault_flag) |-> $past(cfg_q.fault_detect_enable))
        else $error("fault set while detection off");
    fault_clear_a: assert property (
        $fell(flags_q.mode_fault_flag) |-> $past(ctrl_wr))
        else $error("fault cleared without control write");
    master_fault_a: assert property (
        fault_rise ##0 $past(ctrl_q.master_select_bit) |->
        !ctrl_q.module_enable && flags_q.transmit_empty_flag ##1 pins_free)
        else $error("master fault side effects missing");
    keep_role_a: assert property (
        fault_rise |-> $stable(ctrl_q.master_select_bit))
        else $error("role bit changed by fault");
    slave_fault_a: assert property (
        fault_rise ##0 !$past(ctrl_q.master_select_bit) |->
        $stable(ctrl_q.module_enable))
        else $error("slave fault touched enable");
    off_pins_a: assert property (
        !ctrl_q.module_enable && !$past(ctrl_q.module_enable) |->
        pins_free ##0 flags_q.transmit_empty_flag && !pins_owned)
        else $error("disabled port still drives or empty low");
    // deselect long enough to pass the pin synchronisers
    float_a: assert property (
        (pins_in.select_n && !stop_mode) [*6] |-> !pins_out.miso_oe)
        else $error("deselected slave drives miso");
endmodule
bind sfc_core sfc_chk sfc_chk_inst (.clock, .rst, .ctrl_wr, .stop_mode,
    .pins_in, .pins_out, .ctrl_q, .cfg_q, .flags_q, .tx_irq, .rx_err_irq,
    .wake_req, .pins_owned);
`default_nettype wire

// ### tb/sfc_far.sv
// far side serial device model on the link pins
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------------
// far model
//------------------------------------------------------------------
module sfc_far
    import sfc_pkg::*;
(
    input wire sfc_pin_out_t pins_out,
    output wire sfc_pin_in_t pins_in
);
    logic sck = 1'b0;
    logic sel_n = 1'b1;
    logic mo = 1'b0;
    logic mi = 1'b0;
    logic [7:0] got = 8'h00;
    // wire level: whoever enables its driver owns the line
    assign pins_in.serial_clock_pin = pins_out.sclk_oe ? pins_out.sclk_o : sck;
    assign pins_in.select_n = sel_n;
    assign pins_in.mosi = pins_out.mosi_oe ? pins_out.mosi_o : mo;
    assign pins_in.miso = pins_out.miso_oe ? pins_out.miso_o : mi;
    // undriven miso toggles so stale data never looks valid
    always #2 mi = ~mi;
    // select alone, no clocks
    task automatic select(input logic level);
        sel_n = level;
        #100;
    endtask
    // idle-low clock, n bits msb first, clock still outside frames
    task automatic frame(input logic [7:0] b, input logic cpha, input int n);
        sel_n = 1'b0;
        #48;
        for (int i = 7; i > 7 - n; i--)
        begin
            if (!cpha) mo = b[i];
            #24 sck = 1'b1;
            if (cpha) mo = b[i];
            else got = {got[6:0], pins_in.miso};
            #24 sck = 1'b0;
            if (cpha) got = {got[6:0], pins_in.miso};
        end
        #48 mo = ~mo;
        sel_n = 1'b1;
        #100;
    endtask
endmodule
`default_nettype wire

// ### tb/sfc_core_tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("wrong value %s expected %0h seen %0h", n, e, g); \
        end \
    end
//------------------------------------------------------------------
// bench
//------------------------------------------------------------------
module sfc_core_tb
    import sfc_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ctrl_wr = 1'b0;
    sfc_ctrl_t ctrl_wdata = 6'h00;
    logic cfg_wr = 1'b0;
    sfc_cfg_t cfg_wdata = 4'h0;
    logic status_read = 1'b0;
    logic data_read = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic tx_ready, tx_irq, rx_err_irq, wake_req, pins_owned, ok;
    logic [7:0] rx_data;
    wire sfc_pin_in_t pins_in;
    sfc_pin_out_t pins_out;
    sfc_ctrl_t ctrl_q;
    sfc_cfg_t cfg_q;
    sfc_flags_t flags_q;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int pushes = 0;
    wire logic [2:0] oes = {pins_out.sclk_oe, pins_out.mosi_oe, pins_out.miso_oe};
    sfc_core sfc_core_inst (.clock, .rst, .ctrl_wr,
        .ctrl_wdata, .cfg_wr, .cfg_wdata, .status_read, .data_read, .tx_data,
        .tx_valid, .tx_ready, .wait_mode, .stop_mode, .pins_in, .pins_out,
        .ctrl_q, .cfg_q, .flags_q, .rx_data, .tx_irq, .rx_err_irq, .wake_req,
        .pins_owned);
    sfc_far sfc_far_inst (.pins_out, .pins_in);
    initial forever #2 clock = ~clock;
    // hang guard, far above the few thousand cycles expected
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // link pins pass two synchronisers, so allow a margin
    task automatic settle();
        repeat (8) @(posedge clock);
        #1;
    endtask
    // one write pulse to either the control or the configuration bits
    task automatic put(input logic to_cfg, input logic [5:0] v);
        @(posedge clock);
        ctrl_wdata <= v;
        cfg_wdata <= v[3:0];
        ctrl_wr <= !to_cfg;
        cfg_wr <= to_cfg;
        @(posedge clock);
        ctrl_wr <= 1'b0;
        cfg_wr <= 1'b0;
        settle();
    endtask
    task automatic put_ctrl(input logic [5:0] v);
        put(1'b0, v);
    endtask
    task automatic put_cfg(input logic [3:0] v);
        put(1'b1, {2'b00, v});
    endtask
    // status read, then data read or control write
    task automatic read_then(input logic wr, input logic [5:0] v);
        @(posedge clock);
        status_read <= 1'b1;
        @(posedge clock);
        status_read <= 1'b0;
        data_read <= !wr;
        ctrl_wr <= wr;
        ctrl_wdata <= v;
        @(posedge clock);
        data_read <= 1'b0;
        ctrl_wr <= 1'b0;
        settle();
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        settle();
        `CHK("role", 1'b1, ctrl_q.master_select_bit)
        `CHK("enable", 1'b0, ctrl_q.module_enable)
        `CHK("cfg", 4'h0, cfg_q)
        `CHK("flags", 4'h4, flags_q)
        tx_data <= 8'hA0;
        tx_valid <= 1'b1;
        repeat (40)
        begin
            @(negedge clock);
            ok = tx_ready;
            @(posedge clock);
            if (ok)
            begin
                pushes++;
                tx_data <= tx_data + 8'h01;
            end
        end
        tx_valid <= 1'b0;
        `CHK("pushes", 32, pushes)
        `CHK("tx empty", 1'b1, flags_q.transmit_empty_flag)
        put_cfg(4'hC);
        put_ctrl(6'h22);
        `CHK("tx empty", 1'b0, flags_q.transmit_empty_flag)
        sfc_far_inst.frame(8'h5A, 1'b0, 8);
        settle();
        `CHK("rx", 8'h5A, rx_data)
        `CHK("flags", 4'h8, flags_q)
        `CHK("miso", 8'hA0, sfc_far_inst.got)
        `CHK("rx irq", 1'b1, rx_err_irq)
        sfc_far_inst.frame(8'hC3, 1'b0, 8);
        settle();
        `CHK("flags", 4'hA, flags_q)
        `CHK("rx kept", 8'h5A, rx_data)
        `CHK("miso", 8'hA1, sfc_far_inst.got)
        put_ctrl(6'h20);
        `CHK("flags", 4'hE, flags_q)
        `CHK("rx irq", 1'b1, rx_err_irq)
        read_then(1'b0, 6'h20);
        `CHK("flags", 4'h4, flags_q)
        put_ctrl(6'h02);
        sfc_far_inst.select(1'b0);
        sfc_far_inst.select(1'b1);
        settle();
        `CHK("fault", 1'b1, flags_q.mode_fault_flag)
        `CHK("ctrl", 6'h02, ctrl_q)
        `CHK("err irq", 1'b1, rx_err_irq)
        wait_mode <= 1'b1;
        read_then(1'b1, 6'h06);
        `CHK("wake", 1'b1, wake_req)
        `CHK("fault", 1'b1, flags_q.mode_fault_flag)
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        put_ctrl(6'h06);
        `CHK("ctrl", 6'h02, ctrl_q)
        stop_mode <= 1'b0;
        read_then(1'b1, 6'h06);
        `CHK("fault", 1'b0, flags_q.mode_fault_flag)
        sfc_far_inst.select(1'b0);
        sfc_far_inst.select(1'b1);
        settle();
        `CHK("fault", 1'b0, flags_q.mode_fault_flag)
        sfc_far_inst.frame(8'h96, 1'b1, 4);
        settle();
        `CHK("fault", 1'b1, flags_q.mode_fault_flag)
        read_then(1'b1, 6'h06);
        put_cfg(4'h4);
        sfc_far_inst.frame(8'h96, 1'b1, 4);
        settle();
        `CHK("fault", 1'b0, flags_q.mode_fault_flag)
        // slowest rate keeps a master byte from finishing first
        put_cfg(4'hF);
        put_ctrl(6'h13);
        sfc_far_inst.select(1'b0);
        settle();
        `CHK("ctrl", 6'h11, ctrl_q)
        `CHK("flags", 4'h5, flags_q)
        `CHK("oe", 3'h0, oes)
        `CHK("tx irq", 1'b0, tx_irq)
        read_then(1'b1, 6'h12);
        `CHK("fault", 1'b1, flags_q.mode_fault_flag)
        sfc_far_inst.select(1'b1);
        read_then(1'b1, 6'h10);
        `CHK("fault", 1'b0, flags_q.mode_fault_flag)
        put_cfg(4'h0);
        put_ctrl(6'h12);
        `CHK("oe", 3'h6, oes)
        repeat (1500) @(posedge clock);
        #1;
        `CHK("flags", 4'hE, flags_q)
        `CHK("sclk idle", 1'b0, pins_out.sclk_o)
        conclude();
    end
endmodule
`default_nettype wire
